// ===== src/cmpl_pkg.sv
// package: register map, field layout and types of the comparator back end
package cmpl_pkg;
	localparam int NUM_CMP = 4; // comparators and lookup tables
	localparam int ADDR_W = 8; // register port address width
	localparam int DATA_W = 16; // register port data width
	// register offsets, the first four are bases of four-register groups
	localparam logic [7:0] OFS_CLK_CFG = 8'h00; // 4 sync clock configs
	localparam logic [7:0] OFS_TRIM = 8'h04; // 4 offset trims
	localparam logic [7:0] OFS_CTRL = 8'h08; // 4 channel controls
	localparam logic [7:0] OFS_LUT_CTRL = 8'h0c; // 4 table controls
	localparam logic [7:0] OFS_LIVE = 8'h10; // live comparator state
	localparam logic [7:0] OFS_STICKY = 8'h11; // sticky table status
	localparam logic [7:0] OFS_MASK = 8'h12; // table irq mask
	// field positions
	localparam int CLK_SRC_LSB = 0; // source select [2:0]
	localparam int CLK_EN_BIT = 3; // clock gate
	localparam int CLK_BYP_BIT = 4; // bypass sync
	localparam int CAL_EN_BIT = 4; // short inputs for calibration
	localparam int LUT_A_LSB = 0; // input a select [1:0]
	localparam int LUT_B_LSB = 4; // input b select [5:4]
	localparam int LUT_FN_LSB = 8; // function word [11:8]
	// reset values
	localparam logic [7:0] RST_CFG8 = 8'h00; // 8-bit registers
	localparam logic [11:0] RST_LUT = 12'h000; // table controls
	localparam logic [3:0] RST_NIB = 4'h0; // 4-bit status and mask
	localparam logic [15:0] RD_ZERO = 16'h0000; // unmapped read
	// function words used by checks
	localparam logic [3:0] FN_AND = 4'h1;
	localparam logic [3:0] FN_XOR = 4'h6;
	// sync clock configuration
	typedef struct packed {
		logic [2:0] rsv; // reserved, reads back zero
		logic bypass; // pass raw output on
		logic clk_en; // run the selected clock
		logic [2:0] src; // 0..3 analog, 4..7 fabric
	} cmpl_clk_cfg_s;
	// offset trim, top bit polarity, low three bits magnitude
	typedef struct packed {
		logic fine_pol;
		logic [2:0] fine_mag;
		logic coarse_pol;
		logic [2:0] coarse_mag;
	} cmpl_trim_s;
	// register port request
	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} cmpl_req_s;
endpackage : cmpl_pkg

// ===== src/cmpl_sync_chan.sv
// one comparator output synchroniser with clock select, gate and bypass
`timescale 1ns/1ps
module cmpl_sync_chan (
	input wire logic core_clk,
	input wire logic arst_n,
	input cmpl_pkg::cmpl_clk_cfg_s cfg,
	input wire logic [3:0] ana_clk,
	input wire logic [3:0] fab_clk,
	input wire logic raw,
	output logic out
);
	import cmpl_pkg::*;
	logic [7:0] src_vec; // all selectable clocks
	logic sel_clk; // chosen clock level
	logic sel_prev; // its level one cycle ago
	logic tick; // gated rising edge of chosen clock
	logic s1; // first stage
	logic s2; // second stage
	assign src_vec = {fab_clk, ana_clk};
	assign sel_clk = src_vec[cfg.src];
	assign tick = cfg.clk_en & sel_clk & ~sel_prev;
	// edge detect of the selected clock
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) sel_prev <= 1'b0;
		else sel_prev <= sel_clk;
	end
	// two stages stepped by the chosen clock; s1 only feeds s2
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
		end else if (tick) begin
			s1 <= raw;
			s2 <= s1;
		end
	end
	assign out = cfg.bypass ? raw : s2;
	property p_gate_stops;
		@(posedge core_clk) disable iff (!arst_n)
		(!cfg.clk_en && !cfg.bypass) |=> $stable(s2);
	endproperty
	a_gate_stops: assert property (p_gate_stops)
		else $error("sync stage moved with clock gated off");
endmodule : cmpl_sync_chan

// ===== src/cmpl_top.sv
// comparator digital back end: sync, live state, tables, sticky status
`timescale 1ns/1ps
module cmpl_top (
	input wire logic core_clk,
	input wire logic arst_n,
	input cmpl_pkg::cmpl_req_s req,
	output logic [cmpl_pkg::DATA_W-1:0] rdata,
	input wire logic [3:0] cmp_raw,
	input wire logic [3:0] ana_clk,
	input wire logic [3:0] fab_clk,
	output cmpl_pkg::cmpl_trim_s [3:0] trim_out,
	output logic [3:0] cal_short,
	output logic [3:0] table_out,
	output logic [3:0] table_irq
);
	import cmpl_pkg::*;
	cmpl_clk_cfg_s [3:0] clk_cfg; // sync clock configs
	logic [3:0][7:0] trim; // offset trims
	logic [3:0][7:0] ctrl; // channel controls
	logic [3:0][11:0] lut_ctrl; // table controls
	logic [3:0] live; // live comparator state
	logic [3:0] sticky; // sticky table status
	logic [3:0] mask; // table irq mask
	logic [3:0] synced; // outputs after sync stage
	logic [3:0] next_table; // table results this cycle
	logic [3:0] next_sticky; // sticky status next value
	logic [DATA_W-1:0] next_rdata; // read mux
	logic [1:0] idx; // register index inside a group
	logic wr_cfg, wr_trim, wr_ctrl, wr_lut, wr_mask; // write decode
	logic rd_sticky; // read of sticky status
	// decode a group of four registers at a base offset
	function automatic logic in_grp(input logic [7:0] a, input logic [7:0] b);
		in_grp = (a[7:2] == b[7:2]);
	endfunction : in_grp
	// two-input table: bit 3 answers a=0 b=0, bit 0 answers a=1 b=1
	function automatic logic lut_eval(input logic [3:0] fn, input logic a,
		input logic b);
		logic [1:0] k;
		k = {~a, ~b};
		lut_eval = fn[k];
	endfunction : lut_eval
	assign idx = req.addr[1:0];
	assign wr_cfg = req.wr_en & in_grp(req.addr, OFS_CLK_CFG);
	assign wr_trim = req.wr_en & in_grp(req.addr, OFS_TRIM);
	assign wr_ctrl = req.wr_en & in_grp(req.addr, OFS_CTRL);
	assign wr_lut = req.wr_en & in_grp(req.addr, OFS_LUT_CTRL);
	assign wr_mask = req.wr_en & (req.addr == OFS_MASK);
	assign rd_sticky = req.rd_en & (req.addr == OFS_STICKY);
	// per-channel sync, table and output wiring
	genvar g;
	generate
		for (g = 0; g < NUM_CMP; g++) begin : g_ch
			logic [1:0] sa; // input a select
			logic [1:0] sb; // input b select
			cmpl_sync_chan u_sync (
				.core_clk(core_clk),
				.arst_n(arst_n),
				.cfg(clk_cfg[g]),
				.ana_clk(ana_clk),
				.fab_clk(fab_clk),
				.raw(cmp_raw[g]),
				.out(synced[g])
			);
			assign sa = lut_ctrl[g][LUT_A_LSB +: 2];
			assign sb = lut_ctrl[g][LUT_B_LSB +: 2];
			assign next_table[g] = lut_eval(lut_ctrl[g][LUT_FN_LSB +: 4],
				live[sa], live[sb]);
			assign trim_out[g] = cmpl_trim_s'(trim[g]);
			assign cal_short[g] = ctrl[g][CAL_EN_BIT];
		end
	endgenerate
	// sticky: read clears, a set in the same cycle wins
	assign next_sticky = (rd_sticky ? RST_NIB : sticky) | next_table;
	assign table_irq = sticky & mask;
	// read mux
	always_comb begin
		next_rdata = RD_ZERO;
		if (req.rd_en) begin
			case (1'b1)
				in_grp(req.addr, OFS_CLK_CFG):
					next_rdata = {8'h00, 3'b000, clk_cfg[idx][4:0]};
				in_grp(req.addr, OFS_TRIM): next_rdata = {8'h00, trim[idx]};
				in_grp(req.addr, OFS_CTRL): next_rdata = {8'h00, ctrl[idx]};
				in_grp(req.addr, OFS_LUT_CTRL):
					next_rdata = {4'h0, lut_ctrl[idx]};
				(req.addr == OFS_LIVE): next_rdata = {12'h000, live};
				(req.addr == OFS_STICKY): next_rdata = {12'h000, sticky};
				(req.addr == OFS_MASK): next_rdata = {12'h000, mask};
				default: next_rdata = RD_ZERO;
			endcase
		end
	end
	// configuration writes
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			clk_cfg <= '0;
			trim <= '0;
			ctrl <= '0;
			lut_ctrl <= '0;
			mask <= RST_NIB;
		end else begin
			if (wr_cfg) clk_cfg[idx] <= cmpl_clk_cfg_s'({3'b000,
				req.wdata[4:0]});
			if (wr_trim) trim[idx] <= req.wdata[7:0];
			if (wr_ctrl) ctrl[idx] <= req.wdata[7:0];
			if (wr_lut) lut_ctrl[idx] <= req.wdata[11:0];
			if (wr_mask) mask <= req.wdata[3:0];
		end
	end
	// state: live outputs, table results, sticky, read data
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			live <= RST_NIB;
			table_out <= RST_NIB;
			sticky <= RST_NIB;
			rdata <= RD_ZERO;
		end else begin
			live <= synced;
			table_out <= next_table;
			sticky <= next_sticky;
			rdata <= next_rdata;
		end
	end
	property p_clear_on_read;
		@(posedge core_clk) disable iff (!arst_n)
		rd_sticky |=> sticky == $past(next_table);
	endproperty
	a_clear_on_read: assert property (p_clear_on_read)
		else $error("sticky status not cleared by read");
	property p_sticky_set;
		@(posedge core_clk) disable iff (!arst_n)
		next_table[0] |=> sticky[0] ##1 (sticky[0] || $past(rd_sticky));
	endproperty
	a_sticky_set: assert property (p_sticky_set)
		else $error("table result lost from sticky status");
	property p_irq_masked;
		@(posedge core_clk) disable iff (!arst_n)
		(wr_mask && req.wdata[0] == 1'b0) |=> !table_irq[0];
	endproperty
	a_irq_masked: assert property (p_irq_masked)
		else $error("interrupt raised while masked");
	property p_live_read;
		@(posedge core_clk) disable iff (!arst_n)
		(req.rd_en && req.addr == OFS_LIVE) |=> rdata[3:0] == $past(live);
	endproperty
	a_live_read: assert property (p_live_read)
		else $error("live state read back wrong");
	property p_cal_short;
		@(posedge core_clk) disable iff (!arst_n)
		(wr_ctrl && idx == 2'd1) |=> cal_short[1] == $past(req.wdata[4]);
	endproperty
	a_cal_short: assert property (p_cal_short)
		else $error("calibration short does not follow control bit");
	property p_trim_out;
		@(posedge core_clk) disable iff (!arst_n)
		(wr_trim && idx == 2'd2) |=> trim_out[2] == $past(req.wdata[7:0]);
	endproperty
	a_trim_out: assert property (p_trim_out)
		else $error("trim fields not driven from trim register");
	property p_and_fn;
		@(posedge core_clk) disable iff (!arst_n)
		(lut_ctrl[0][11:8] == FN_AND) |=> table_out[0] ==
			$past(live[lut_ctrl[0][1:0]] & live[lut_ctrl[0][5:4]]);
	endproperty
	a_and_fn: assert property (p_and_fn)
		else $error("and function wrong");
	property p_xor_fn;
		@(posedge core_clk) disable iff (!arst_n)
		(lut_ctrl[3][11:8] == FN_XOR) |=> table_out[3] ==
			$past(live[lut_ctrl[3][1:0]] ^ live[lut_ctrl[3][5:4]]);
	endproperty
	a_xor_fn: assert property (p_xor_fn)
		else $error("xor function or input select wrong");
	property p_bypass;
		@(posedge core_clk) disable iff (!arst_n)
		clk_cfg[0].bypass |=> live[0] == $past(cmp_raw[0]);
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("bypass does not pass raw output");
	// no read, no read data
	property p_rdata_idle;
		@(posedge core_clk) disable iff (!arst_n)
		!req.rd_en |=> rdata == RD_ZERO;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not zero without a read");
	// holes above the map read as zero
	property p_unmapped_read;
		@(posedge core_clk) disable iff (!arst_n)
		(req.rd_en && req.addr > OFS_MASK) |=> rdata == RD_ZERO;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read)
		else $error("unmapped read returned data");
	// clock config write lands in its slot, reserved bits zero
	property p_cfg_write;
		@(posedge core_clk) disable iff (!arst_n)
		(wr_cfg && idx == 2'd3) |=>
			clk_cfg[3] == {3'b000, $past(req.wdata[4:0])};
	endproperty
	a_cfg_write: assert property (p_cfg_write)
		else $error("clock config write lost");
	// clock config reads back its five live bits
	property p_cfg_read;
		@(posedge core_clk) disable iff (!arst_n)
		(req.rd_en && req.addr == OFS_CLK_CFG) |=>
			rdata == {11'h000, $past(clk_cfg[0][4:0])};
	endproperty
	a_cfg_read: assert property (p_cfg_read)
		else $error("clock config read back wrong");
	// trim register reads back whole
	property p_trim_read;
		@(posedge core_clk) disable iff (!arst_n)
		(req.rd_en && req.addr == OFS_TRIM) |=>
			rdata == {8'h00, $past(trim[0])};
	endproperty
	a_trim_read: assert property (p_trim_read)
		else $error("trim read back wrong");
	// channel control reads back whole
	property p_ctrl_read;
		@(posedge core_clk) disable iff (!arst_n)
		(req.rd_en && req.addr == OFS_CTRL) |=>
			rdata == {8'h00, $past(ctrl[0])};
	endproperty
	a_ctrl_read: assert property (p_ctrl_read)
		else $error("channel control read back wrong");
	// table control reads back its twelve bits
	property p_lut_read;
		@(posedge core_clk) disable iff (!arst_n)
		(req.rd_en && req.addr == OFS_LUT_CTRL) |=>
			rdata == {4'h0, $past(lut_ctrl[0])};
	endproperty
	a_lut_read: assert property (p_lut_read)
		else $error("table control read back wrong");
	// mask reads back
	property p_mask_read;
		@(posedge core_clk) disable iff (!arst_n)
		(req.rd_en && req.addr == OFS_MASK) |=>
			rdata == {12'h000, $past(mask)};
	endproperty
	a_mask_read: assert property (p_mask_read)
		else $error("mask read back wrong");
	// sticky read returns the bits held before the clear
	property p_sticky_rdata;
		@(posedge core_clk) disable iff (!arst_n)
		rd_sticky |=> rdata == {12'h000, $past(sticky)};
	endproperty
	a_sticky_rdata: assert property (p_sticky_rdata)
		else $error("sticky read data wrong");
	// sticky bits only fall through a read
	property p_sticky_hold;
		@(posedge core_clk) disable iff (!arst_n)
		!rd_sticky |=> (sticky | $past(sticky)) == sticky;
	endproperty
	a_sticky_hold: assert property (p_sticky_hold)
		else $error("sticky bit fell without a read");
	// every table result lands in sticky status
	property p_table_sticky;
		@(posedge core_clk) disable iff (!arst_n)
		1'b1 |=> (sticky & $past(next_table)) == $past(next_table);
	endproperty
	a_table_sticky: assert property (p_table_sticky)
		else $error("table result missing from sticky status");
	// a mask write silences masked tables at once
	property p_irq_masked_all;
		@(posedge core_clk) disable iff (!arst_n)
		wr_mask |=> (table_irq & ~$past(req.wdata[3:0])) == RST_NIB;
	endproperty
	a_irq_masked_all: assert property (p_irq_masked_all)
		else $error("masked table raised an interrupt");
	// an unmasked table result raises its interrupt next cycle
	property p_irq_follow;
		@(posedge core_clk) disable iff (!arst_n)
		(mask[0] && next_table[0] && !wr_mask) |=> table_irq[0];
	endproperty
	a_irq_follow: assert property (p_irq_follow)
		else $error("unmasked table raised no interrupt");
	// a second bypassed channel passes raw output on
	property p_bypass_two;
		@(posedge core_clk) disable iff (!arst_n)
		clk_cfg[2].bypass |=> live[2] == $past(cmp_raw[2]);
	endproperty
	a_bypass_two: assert property (p_bypass_two)
		else $error("bypass on channel two does not pass raw");
	// all zero function word gives false
	property p_false_fn;
		@(posedge core_clk) disable iff (!arst_n)
		(lut_ctrl[1][LUT_FN_LSB +: 4] == RST_NIB) |=> !table_out[1];
	endproperty
	a_false_fn: assert property (p_false_fn)
		else $error("false function wrong");
	// all one function word gives true
	property p_true_fn;
		@(posedge core_clk) disable iff (!arst_n)
		(lut_ctrl[2][LUT_FN_LSB +: 4] == ~RST_NIB) |=> table_out[2];
	endproperty
	a_true_fn: assert property (p_true_fn)
		else $error("true function wrong");
	// inverted and word gives nand
	property p_nand_fn;
		@(posedge core_clk) disable iff (!arst_n)
		(lut_ctrl[1][11:8] == ~FN_AND) |=> table_out[1] ==
			!$past(live[lut_ctrl[1][1:0]] & live[lut_ctrl[1][5:4]]);
	endproperty
	a_nand_fn: assert property (p_nand_fn)
		else $error("nand function wrong");
	// inverted xor word gives xnor on the selected inputs
	property p_xnor_fn;
		@(posedge core_clk) disable iff (!arst_n)
		(lut_ctrl[2][11:8] == ~FN_XOR) |=> table_out[2] ==
			!$past(live[lut_ctrl[2][1:0]] ^ live[lut_ctrl[2][5:4]]);
	endproperty
	a_xnor_fn: assert property (p_xnor_fn)
		else $error("xnor function or input select wrong");
endmodule : cmpl_top

// ===== testbench/cmpl_far_model.sv
// far side model: comparator cores and fabric clocks
`timescale 1ns/1ps
module cmpl_far_model (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [3:0] level,
	input wire logic fab_run,
	output logic [3:0] cmp_raw,
	output logic [3:0] ana_clk,
	output logic [3:0] fab_clk
);
	logic [3:0] div; // shared divider keeps the analog clocks aligned
	// free divider for the clock sources
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			div <= 4'h0;
		end else begin
			div <= div + 4'h1;
		end
	end
	assign cmp_raw = level;
	assign ana_clk = {4{div[1]}};
	// fabric clock stands still until the fabric is told to run
	assign fab_clk = fab_run ? {4{div[2]}} : 4'h0;
endmodule : cmpl_far_model

// ===== testbench/tb_cmpl_top.sv
// testbench: register port, data path and sticky status of cmpl_top
`timescale 1ns/1ps
module tb_cmpl_top;
	import cmpl_pkg::*;
	logic core_clk; // bench clock
	logic arst_n; // bench reset
	cmpl_req_s req; // register request
	logic [DATA_W-1:0] rdata;
	logic [3:0] cmp_raw;
	logic [3:0] ana_clk;
	logic [3:0] fab_clk;
	cmpl_trim_s [3:0] trim_out;
	logic [3:0] cal_short;
	logic [3:0] table_out;
	logic [3:0] table_irq;
	logic [3:0] level; // comparator levels asked of the model
	logic fab_run;
	logic [31:0] seed;
	logic [15:0] d;
	logic [3:0] fm [4]; // model: function word per table
	int sa [4]; // model: input a select
	int sb [4]; // model: input b select
	int fail_count;
	int checks;
	int i;
	int f;
	cmpl_top u_cmpl_top (.core_clk(core_clk), .arst_n(arst_n), .req(req),
		.rdata(rdata), .cmp_raw(cmp_raw), .ana_clk(ana_clk),
		.fab_clk(fab_clk), .trim_out(trim_out), .cal_short(cal_short),
		.table_out(table_out), .table_irq(table_irq));
	cmpl_far_model u_cmpl_far_model (.core_clk(core_clk), .arst_n(arst_n),
		.level(level), .fab_run(fab_run), .cmp_raw(cmp_raw),
		.ana_clk(ana_clk), .fab_clk(fab_clk));
	// next pseudo-random word
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	// model of the four tables on a given live state
	function automatic logic [3:0] tab(input logic [3:0] lv);
		logic [3:0] r;
		for (int k = 0; k < 4; k++) begin
			r[k] = fm[k][3 - 2 * lv[sa[k]] - lv[sb[k]]];
		end
		return r;
	endfunction : tab
	task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s exp %h got %h", w, e, g);
		end
	endtask : chk
	// write strobe held for exactly one taken edge
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge core_clk);
		req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: v};
		@(posedge core_clk);
		req.wr_en <= 1'b0;
	endtask : wr
	// read data sampled once the registered answer has landed
	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge core_clk);
		req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge core_clk);
		req.rd_en <= 1'b0;
		#1 v = rdata;
	endtask : rd
	task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] v;
		rd(a, v);
		chk("reg", e, v);
	endtask : rdchk
	task automatic test_done;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : test_done
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// watchdog cuts a hang short
	initial begin
		#100us;
		fail_count++;
		test_done();
	end
	initial begin
		req = '0;
		level = 4'h0;
		fab_run = 1'b0;
		arst_n = 1'b0;
		seed = 32'd97039;
		repeat (5) @(posedge core_clk);
		arst_n <= 1'b1;
		// every register clears, 0x13 is unmapped
		for (i = 0; i < 20; i++) rdchk(i[7:0], 16'h0000);
		chk("outs", 16'h0000, {4'h0, cal_short, table_out, table_irq});
		for (i = 0; i < 4; i++) begin
			seed = xs(seed);
			wr(OFS_TRIM + i[7:0], seed[15:0]);
			rdchk(OFS_TRIM + i[7:0], {8'h00, seed[7:0]});
			chk("trim", {8'h00, seed[7:0]}, {8'h00, trim_out[i]});
			chk("fine", {12'h000, seed[7:4]}, {12'h000, trim_out[i].fine_pol,
				trim_out[i].fine_mag});
			wr(OFS_CTRL + i[7:0], {11'h000, i[0], 4'h0});
			wr(OFS_CLK_CFG + i[7:0], 16'h0010);
		end
		chk("cal", 16'h000a, {12'h000, cal_short});
		// every function word on every table, random inputs and levels
		for (f = 0; f < 16; f++) begin
			for (i = 0; i < 4; i++) begin
				seed = xs(seed);
				fm[i] = 4'(f + i * 5);
				sa[i] = seed[1:0];
				sb[i] = seed[5:4];
				wr(OFS_LUT_CTRL + i[7:0], {4'h0, fm[i], 2'b00, seed[5:4], 2'b00,
					seed[1:0]});
			end
			@(posedge core_clk);
			level <= seed[11:8];
			repeat (4) @(posedge core_clk);
			#1 chk("table", {12'h000, tab(seed[11:8])}, {12'h000, table_out});
			rdchk(OFS_LIVE, {12'h000, seed[11:8]});
		end
		for (i = 0; i < 4; i++) wr(OFS_LUT_CTRL + i[7:0], 16'h0000);
		level <= 4'h1; // live bit 0 high for the sticky checks
		repeat (3) @(posedge core_clk);
		rd(OFS_STICKY, d);
		rdchk(OFS_STICKY, 16'h0000);
		wr(OFS_MASK, 16'h0005);
		wr(OFS_LUT_CTRL, 16'h0f00);
		wr(OFS_LUT_CTRL + 8'h01, 16'h0f00);
		repeat (3) @(posedge core_clk);
		#1 chk("irq", 16'h0001, {12'h000, table_irq});
		rdchk(OFS_STICKY, 16'h0003);
		// table 0 follows live bit 0 (high), table 1 goes false
		wr(OFS_LUT_CTRL, 16'h0300);
		wr(OFS_LUT_CTRL + 8'h01, 16'h0000);
		repeat (3) @(posedge core_clk);
		// the last read lost to sets still in force, so both remain
		rdchk(OFS_STICKY, 16'h0003);
		rdchk(OFS_STICKY, 16'h0001);
		chk("irq", 16'h0001, {12'h000, table_irq});
		// live bit 0 falls, so the held bit goes on the next read
		@(posedge core_clk);
		level <= 4'h0;
		repeat (3) @(posedge core_clk);
		rdchk(OFS_STICKY, 16'h0001);
		rdchk(OFS_STICKY, 16'h0000);
		chk("irq", 16'h0000, {12'h000, table_irq});
		// fabric source chosen, its clock still, analog clocks running
		wr(OFS_CLK_CFG, 16'h000c);
		@(posedge core_clk);
		level <= 4'h1;
		repeat (30) @(posedge core_clk);
		rdchk(OFS_LIVE, 16'h0000);
		// fabric clock runs but the gate is shut
		wr(OFS_CLK_CFG, 16'h0004);
		fab_run <= 1'b1;
		repeat (30) @(posedge core_clk);
		rdchk(OFS_LIVE, 16'h0000);
		wr(OFS_CLK_CFG, 16'h000c);
		for (i = 0; i < 60 && table_out[0] !== 1'b1; i++) @(posedge core_clk);
		#1 chk("sync", 16'h0001, {15'h0000, table_out[0]});
		rdchk(OFS_LIVE, 16'h0001);
		test_done();
	end
endmodule : tb_cmpl_top
